// ==== verilog/status_pin_function_select.sv ====
// Purpose: function select and polarity for the rate-select / GENERAL_PURPOSE_OUT pin and the loss / tx-rate pin
// Assumes: pins and supply monitor arrive asynchronously; power level comes from the converter on clk
// Notes: open-drain pins pull low when their enable is high; outputs are registered
//
// Behaviour
// - Function bit 4 low routes receive rate select to the shared pin.
// - Receive rate select is soft bit OR input pin, open-drain only.
// - Function bit 4 high makes the pin a GENERAL_PURPOSE_OUT driven by config bits.
// - Output config bit 2 low: second pin signals received power below threshold.
// - Output config bit 3 picks low or high level as normal operation.
// - Loss indication clears once received power exceeds the threshold.
// - Loss status bit follows the real pin level, even when driven externally.
// - Output config bit 2 high: second pin carries soft tx bit OR input.
// - Reset clears registers; conversions start after 50 microseconds.
// - Supply below undervoltage threshold requests shutdown, best effort.
`timescale 1ns/1ns
module status_pin_function_select
(
   input wire logic clk,
   input wire logic arst_n,
   input wire logic [status_pin_pkg::ADDR_W-1:0] regAddr,
   input wire logic [status_pin_pkg::DATA_W-1:0] regWdata,
   input wire logic regWrite,
   input wire logic regRead,
   output logic [status_pin_pkg::DATA_W-1:0] regRdata,
   input wire logic rxRateSelectIn,
   input wire logic txRateSelectIn,
   input wire logic [status_pin_pkg::LEVEL_W-1:0] receivedPowerLevel,
   input wire logic belowUndervoltage,
   output logic ratePinOut,
   output logic ratePinOe,
   input wire logic lossPinIn,
   output logic lossPinOut,
   output logic lossPinOe,
   output logic convEnable,
   output logic shutdownReq
);
   import status_pin_pkg::*;

   // ------------------------------------------------------------
   // State
   // ------------------------------------------------------------
   typedef struct packed {
      logic [DATA_W-1:0] pinFunc;
      logic [DATA_W-1:0] outCfg;
      logic [DATA_W-1:0] rateCtl;
      logic [LEVEL_W-1:0] lossThreshold;
      logic [3:0] sync1;
      logic [3:0] sync2;
      logic lossActive;
      logic lossStatus;
      logic [POR_CNT_W-1:0] porCount;
      logic convOn;
      logic shutdown;
      logic ratePinOut;
      logic ratePinOe;
      logic lossPinOut;
      logic lossPinOe;
      logic [DATA_W-1:0] rdata;
   } state_t;

   state_t q;
   state_t d;

   always_comb
   begin
      d = q;
      // Second stage only feeds logic; first stage is read by nobody else
      d.sync1 = {belowUndervoltage, lossPinIn, txRateSelectIn, rxRateSelectIn};
      d.sync2 = q.sync1;

      // Equal level holds the last decision, giving no chatter at the edge
      if (receivedPowerLevel > q.lossThreshold)
      begin
         d.lossActive = 1'b0;
      end
      else if (receivedPowerLevel < q.lossThreshold)
      begin
         d.lossActive = 1'b1;
      end

      // Pin level back to loss meaning, whoever drives the wire
      d.lossStatus = q.sync2[SYNC_LOSS] ^ q.outCfg[LOSS_POLARITY_BIT];

      // ------------------------------------------------------------
      // Power-up and undervoltage
      // ------------------------------------------------------------
      if (!q.convOn && !q.shutdown)
      begin
         if (q.porCount == POR_LAST)
         begin
            d.convOn = 1'b1;
         end
         else
         begin
            d.porCount = q.porCount + 1'b1;
         end
      end
      // Latches until the next power-on reset; supply may collapse first
      if (q.sync2[SYNC_UV])
      begin
         d.shutdown = 1'b1;
         d.convOn = 1'b0;
      end

      // ------------------------------------------------------------
      // Pin drive
      // ------------------------------------------------------------
      if (q.pinFunc[GPO_SELECT_BIT])
      begin
         d.ratePinOut = q.pinFunc[GPO_LEVEL_BIT];
         d.ratePinOe = 1'b1;
      end
      else
      begin
         d.ratePinOut = 1'b0;
         d.ratePinOe = !(q.rateCtl[SOFT_RX_RATE_BIT] || q.sync2[SYNC_RX]);
      end

      d.lossPinOut = 1'b0;
      if (q.outCfg[TX_RATE_MODE_BIT])
      begin
         d.lossPinOe = !(q.rateCtl[SOFT_TX_RATE_BIT] || q.sync2[SYNC_TX]);
      end
      else
      begin
         // Polarity 0: released (high) on loss; polarity 1: pulled low on loss
         d.lossPinOe = q.outCfg[LOSS_POLARITY_BIT] ? q.lossActive : !q.lossActive;
      end

      // ------------------------------------------------------------
      // Register port
      // ------------------------------------------------------------
      if (regWrite)
      begin
         case (regAddr)
            PIN_FUNCTION_CONFIG_ADDR: d.pinFunc = regWdata;
            OUTPUT_CONFIG_ADDR: d.outCfg = regWdata;
            RATE_CONTROL_ADDR: d.rateCtl = regWdata;
            LOSS_THRESHOLD_ADDR: d.lossThreshold = regWdata;
            default: d.rdata = q.rdata;
         endcase
      end

      d.rdata = '0;
      if (regRead)
      begin
         case (regAddr)
            PIN_FUNCTION_CONFIG_ADDR: d.rdata = q.pinFunc;
            OUTPUT_CONFIG_ADDR: d.rdata = q.outCfg;
            RATE_CONTROL_ADDR: d.rdata = q.rateCtl;
            LOSS_THRESHOLD_ADDR: d.rdata = q.lossThreshold;
            STATUS_ADDR:
            begin
               d.rdata[STAT_LOSS_PIN_BIT] = q.lossStatus;
               d.rdata[STAT_LOSS_CMP_BIT] = q.lossActive;
               d.rdata[STAT_CONV_BIT] = q.convOn;
               d.rdata[STAT_SHUTDOWN_BIT] = q.shutdown;
            end
            default: d.rdata = '0;
         endcase
      end
   end

   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         q <= '0;
         q.pinFunc <= PIN_FUNCTION_CONFIG_RST;
         q.outCfg <= OUTPUT_CONFIG_RST;
         q.rateCtl <= RATE_CONTROL_RST;
         q.lossThreshold <= LOSS_THRESHOLD_RST;
         q.ratePinOe <= 1'b1;
         q.lossPinOe <= 1'b1;
      end
      else
      begin
         q <= d;
      end
   end

   assign regRdata = q.rdata;
   assign ratePinOut = q.ratePinOut;
   assign ratePinOe = q.ratePinOe;
   assign lossPinOut = q.lossPinOut;
   assign lossPinOe = q.lossPinOe;
   assign convEnable = q.convOn;
   assign shutdownReq = q.shutdown;

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!arst_n);

   sequence rxRateAsked;
      !q.pinFunc[GPO_SELECT_BIT] && (q.rateCtl[SOFT_RX_RATE_BIT] || q.sync2[SYNC_RX]);
   endsequence

   sequence lossMode;
      !q.outCfg[TX_RATE_MODE_BIT];
   endsequence

   chk_rx_rate_release: assert property (rxRateAsked |=> !ratePinOe && !ratePinOut)
      else $error("rate pin not released for rx rate select");
   chk_rx_rate_pull: assert property (!q.pinFunc[GPO_SELECT_BIT] && !q.rateCtl[SOFT_RX_RATE_BIT]
      && !q.sync2[SYNC_RX] |=> ratePinOe && !ratePinOut)
      else $error("rate pin not pulled low with rate select off");
   chk_gpo_level: assert property (q.pinFunc[GPO_SELECT_BIT] |=> ratePinOe
      && ratePinOut == $past(q.pinFunc[GPO_LEVEL_BIT]))
      else $error("gpo pin level wrong");
   chk_loss_assert: assert property (receivedPowerLevel < q.lossThreshold |=> q.lossActive)
      else $error("loss not raised below threshold");
   chk_loss_polarity: assert property (lossMode ##1 lossMode |-> lossPinOe
      == ($past(q.outCfg[LOSS_POLARITY_BIT]) ? $past(q.lossActive) : !$past(q.lossActive)))
      else $error("loss pin polarity wrong");
   chk_loss_clear: assert property (receivedPowerLevel > q.lossThreshold |=> !q.lossActive)
      else $error("loss not cleared above threshold");
   chk_loss_status: assert property ($changed(q.sync2[SYNC_LOSS]) |=>
      q.lossStatus == ($past(q.sync2[SYNC_LOSS]) ^ $past(q.outCfg[LOSS_POLARITY_BIT])))
      else $error("loss status does not follow pin");
   chk_tx_rate: assert property (q.outCfg[TX_RATE_MODE_BIT] |=> !lossPinOut && lossPinOe ==
      !($past(q.rateCtl[SOFT_TX_RATE_BIT]) || $past(q.sync2[SYNC_TX])))
      else $error("tx rate select on loss pin wrong");
   chk_por_start: assert property ($rose(arst_n) ##0 !q.sync2[SYNC_UV] [*8] |-> !convEnable)
      else $error("conversions started too early");
   chk_por_done: assert property (!q.convOn && !q.shutdown && q.porCount == POR_LAST
      && !q.sync2[SYNC_UV] |=> convEnable)
      else $error("conversions not started at end of reset time");
   chk_uv_shutdown: assert property (q.sync2[SYNC_UV] |=> shutdownReq && !convEnable ##1 shutdownReq)
      else $error("undervoltage did not request shutdown");

   // ------------------------------------------------------------
   // Checks: register port
   // ------------------------------------------------------------
   sequence statusRead;
      regRead && regAddr == STATUS_ADDR;
   endsequence

   sequence statusWrite;
      regWrite && regAddr == STATUS_ADDR;
   endsequence

   // Read data stand one cycle only; software must not poll them later
   chk_rdata_idle: assert property (!regRead |=> regRdata == '0)
      else $error("read data not zero outside a read");

   chk_rdata_on_write: assert property (regWrite |=> regRdata == '0)
      else $error("read data not zero after a write");

   chk_read_pinfunc: assert property (regRead && regAddr == PIN_FUNCTION_CONFIG_ADDR
      |=> regRdata == $past(q.pinFunc))
      else $error("pin function read back wrong");

   chk_read_outcfg: assert property (regRead && regAddr == OUTPUT_CONFIG_ADDR
      |=> regRdata == $past(q.outCfg))
      else $error("output config read back wrong");

   chk_read_ratectl: assert property (regRead && regAddr == RATE_CONTROL_ADDR
      |=> regRdata == $past(q.rateCtl))
      else $error("rate control read back wrong");

   chk_read_thresh: assert property (regRead && regAddr == LOSS_THRESHOLD_ADDR
      |=> regRdata == $past(q.lossThreshold))
      else $error("loss threshold read back wrong");

   chk_read_unmapped: assert property (regRead && regAddr > STATUS_ADDR
      |=> regRdata == '0)
      else $error("unmapped read not zero");

   chk_write_pinfunc: assert property (regWrite && regAddr == PIN_FUNCTION_CONFIG_ADDR
      |=> q.pinFunc == $past(regWdata))
      else $error("pin function write lost");

   chk_write_outcfg: assert property (regWrite && regAddr == OUTPUT_CONFIG_ADDR
      |=> q.outCfg == $past(regWdata))
      else $error("output config write lost");

   chk_write_ratectl: assert property (regWrite && regAddr == RATE_CONTROL_ADDR
      |=> q.rateCtl == $past(regWdata))
      else $error("rate control write lost");

   chk_write_thresh: assert property (regWrite && regAddr == LOSS_THRESHOLD_ADDR
      |=> q.lossThreshold == $past(regWdata))
      else $error("loss threshold write lost");

   chk_status_ro: assert property (statusWrite |=> $stable(q.pinFunc) && $stable(q.outCfg)
      && $stable(q.rateCtl) && $stable(q.lossThreshold))
      else $error("status write changed a register");

   chk_cfg_hold: assert property (!regWrite |=> $stable(q.pinFunc) && $stable(q.outCfg)
      && $stable(q.rateCtl) && $stable(q.lossThreshold))
      else $error("register changed without a write");

   // ------------------------------------------------------------
   // Checks: pins and loss status
   // ------------------------------------------------------------
   chk_rate_out_low: assert property (!q.pinFunc[GPO_SELECT_BIT] |=> !ratePinOut)
      else $error("rate pin driven high in open-drain mode");

   chk_loss_out_low: assert property (!lossPinOut)
      else $error("loss pin driven high");

   chk_loss_hold: assert property (receivedPowerLevel == q.lossThreshold |=> $stable(q.lossActive))
      else $error("loss state moved at equal level");

   // Polarity 0 shows loss as a released wire
   chk_loss_release: assert property (!q.outCfg[TX_RATE_MODE_BIT] && !q.outCfg[LOSS_POLARITY_BIT]
      && q.lossActive |=> !lossPinOe)
      else $error("loss pin not released on loss");

   chk_loss_pull: assert property (!q.outCfg[TX_RATE_MODE_BIT] && q.outCfg[LOSS_POLARITY_BIT]
      && q.lossActive |=> lossPinOe)
      else $error("loss pin not pulled on loss");

   chk_status_bits: assert property (statusRead |=> regRdata[STAT_LOSS_PIN_BIT] == $past(q.lossStatus)
      && regRdata[STAT_LOSS_CMP_BIT] == $past(q.lossActive))
      else $error("status loss bits wrong");

   // ------------------------------------------------------------
   // Checks: power-up and undervoltage
   // ------------------------------------------------------------
   chk_por_count: assert property (!q.convOn && !q.shutdown && q.porCount != POR_LAST
      && !q.sync2[SYNC_UV] |=> q.porCount == $past(q.porCount) + 1'b1)
      else $error("reset timer did not advance");

   chk_conv_wait: assert property (!q.convOn && q.porCount != POR_LAST
      |=> !convEnable)
      else $error("conversions started before reset time");

   chk_conv_hold: assert property (q.convOn && !q.sync2[SYNC_UV] |=> convEnable)
      else $error("conversions stopped without undervoltage");

   chk_status_power: assert property (statusRead |=> regRdata[STAT_CONV_BIT] == $past(q.convOn)
      && regRdata[STAT_SHUTDOWN_BIT] == $past(q.shutdown)
      && regRdata[DATA_W-1:STAT_SHUTDOWN_BIT+1] == '0)
      else $error("status power bits wrong");

   // Sticky so a slow supply collapse still sees the request
   chk_shutdown_sticky: assert property (shutdownReq |=> shutdownReq)
      else $error("shutdown request dropped");

   chk_shutdown_noconv: assert property (shutdownReq |-> !convEnable)
      else $error("conversions running during shutdown");

   chk_por_frozen: assert property (q.shutdown |=> $stable(q.porCount))
      else $error("reset timer runs during shutdown");

endmodule

// ==== verilog/status_pin_pkg.sv ====
// Purpose: constants for the status pin function select block
// Assumes: 8-bit register port, 25 MHz clock
// Notes: register offsets are word indices on the plain port
package status_pin_pkg;
   localparam int ADDR_W = 3;
   localparam int DATA_W = 8;
   localparam int LEVEL_W = 8;

   // ------------------------------------------------------------
   // Register offsets
   // ------------------------------------------------------------
   localparam logic [ADDR_W-1:0] PIN_FUNCTION_CONFIG_ADDR = 3'h0;
   localparam logic [ADDR_W-1:0] OUTPUT_CONFIG_ADDR = 3'h1;
   localparam logic [ADDR_W-1:0] RATE_CONTROL_ADDR = 3'h2;
   localparam logic [ADDR_W-1:0] LOSS_THRESHOLD_ADDR = 3'h3;
   localparam logic [ADDR_W-1:0] STATUS_ADDR = 3'h4;

   // ------------------------------------------------------------
   // Field positions
   // ------------------------------------------------------------
   localparam int GPO_SELECT_BIT = 4;
   localparam int GPO_LEVEL_BIT = 5;
   localparam int TX_RATE_MODE_BIT = 2;
   localparam int LOSS_POLARITY_BIT = 3;
   localparam int SOFT_RX_RATE_BIT = 0;
   localparam int SOFT_TX_RATE_BIT = 1;
   localparam int STAT_LOSS_PIN_BIT = 0;
   localparam int STAT_LOSS_CMP_BIT = 1;
   localparam int STAT_CONV_BIT = 2;
   localparam int STAT_SHUTDOWN_BIT = 3;

   // Synchroniser lanes
   localparam int SYNC_RX = 0;
   localparam int SYNC_TX = 1;
   localparam int SYNC_LOSS = 2;
   localparam int SYNC_UV = 3;

   // ------------------------------------------------------------
   // Reset values
   // ------------------------------------------------------------
   localparam logic [DATA_W-1:0] PIN_FUNCTION_CONFIG_RST = 8'h00;
   localparam logic [DATA_W-1:0] OUTPUT_CONFIG_RST = 8'h00;
   localparam logic [DATA_W-1:0] RATE_CONTROL_RST = 8'h00;
   localparam logic [DATA_W-1:0] LOSS_THRESHOLD_RST = 8'h00;

   // ------------------------------------------------------------
   // Timing
   // ------------------------------------------------------------
   localparam int CLK_FREQ_MHZ = 25;
   localparam int POR_TIME_US = 50;
   localparam int POR_CYCLES = POR_TIME_US * CLK_FREQ_MHZ;
   localparam int POR_CNT_W = 11;
   localparam logic [POR_CNT_W-1:0] POR_LAST = POR_CNT_W'(POR_CYCLES - 1);
endpackage

// ==== test/far_side_model.sv ====
// Purpose: pull-ups on the two shared pins and external signal-detect circuit on the loss pin
// Assumes: both wires carry pull-ups to the host supply
// Notes: a released wire reads high, never the last driven value
`timescale 1ns/1ns
module far_side_model
(
   input wire logic ratePinOut,
   input wire logic ratePinOe,
   input wire logic lossPinOut,
   input wire logic lossPinOe,
   input wire logic extPullLow,
   output logic rateWire,
   output logic lossWire
);
   assign rateWire = ratePinOe ? ratePinOut : 1'b1;
   // External circuit wire-ORed on the loss pin
   assign lossWire = ((lossPinOe && !lossPinOut) || extPullLow) ? 1'b0 : 1'b1;
endmodule

// ==== test/tb.sv ====
// Purpose: self-checking bench for the status pin function select block
// Assumes: 25 MHz clock, register index map of the package
// Notes: pin waits are the fixed synchroniser and output latencies
`timescale 1ns/1ns
module tb;
   import status_pin_pkg::*;
   logic clk = 0, arst_n = 0, regWrite = 0, regRead = 0, rxIn = 0, txIn = 0, uv = 0, extPull = 0;
   logic [2:0] regAddr = 3'h0;
   logic [7:0] regWdata = 8'h00, level = 8'hff, rd;
   logic [7:0] regRdata;
   logic ratePinOut, ratePinOe, lossPinOut, lossPinOe, convEnable, shutdownReq, rateWire, lossWire;
   int errors = 0, n_checks = 0, cycles = 0;
   status_pin_function_select DUT (.clk(clk), .arst_n(arst_n), .regAddr(regAddr), .regWdata(regWdata),
      .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata), .rxRateSelectIn(rxIn),
      .txRateSelectIn(txIn), .receivedPowerLevel(level), .belowUndervoltage(uv), .ratePinOut(ratePinOut),
      .ratePinOe(ratePinOe), .lossPinIn(lossWire), .lossPinOut(lossPinOut), .lossPinOe(lossPinOe),
      .convEnable(convEnable), .shutdownReq(shutdownReq));
   far_side_model far (.ratePinOut(ratePinOut), .ratePinOe(ratePinOe), .lossPinOut(lossPinOut),
      .lossPinOe(lossPinOe), .extPullLow(extPull), .rateWire(rateWire), .lossWire(lossWire));
   initial forever #20 clk = ~clk;
   // ------------------------------------------------------------
   // Bus and compare tasks
   // ------------------------------------------------------------
   task automatic check(input logic [7:0] got, input logic [7:0] exp);
      n_checks++;
      if (got !== exp)
      begin
         errors++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      @(posedge clk);
      regWrite <= 1'b1;
      regAddr <= a;
      regWdata <= d;
      @(posedge clk);
      regWrite <= 1'b0;
   endtask
   task automatic rdr(input logic [2:0] a);
      @(posedge clk);
      regRead <= 1'b1;
      regAddr <= a;
      @(posedge clk);
      regRead <= 1'b0;
      @(negedge clk);
      rd = regRdata;
   endtask
   // Covers the 3-edge synchroniser path with margin
   task automatic settle();
      repeat (4) @(posedge clk);
      @(negedge clk);
   endtask
   task automatic conclude();
      if (errors == 0 && n_checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   // ------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------
   task automatic t_reset();
      for (int a = 0; a < 4; a++)
      begin
         rdr(3'(a));
         check(rd, 8'h00);
      end
      rdr(3'h5);
      check(rd, 8'h00);
      wr(STATUS_ADDR, 8'hff);
      rdr(PIN_FUNCTION_CONFIG_ADDR);
      check(rd, 8'h00);
      check(convEnable, 1'b0);
      repeat (POR_CYCLES + 10) @(posedge clk);
      @(negedge clk);
      check(convEnable, 1'b1);
      rdr(STATUS_ADDR);
      check(rd, 8'h04);
      @(negedge clk);
      check(regRdata, 8'h00);
   endtask
   task automatic t_rx();
      for (int i = 0; i < 4; i++)
      begin
         wr(RATE_CONTROL_ADDR, {7'h0, i[1]});
         rxIn <= i[0];
         settle();
         check(rateWire, i[0] | i[1]);
         check(ratePinOut, 1'b0);
      end
      rxIn <= 1'b0;
      wr(RATE_CONTROL_ADDR, 8'h00);
   endtask
   task automatic t_gpo();
      wr(PIN_FUNCTION_CONFIG_ADDR, 8'h30);
      settle();
      check({ratePinOe, rateWire}, 2'b11);
      wr(PIN_FUNCTION_CONFIG_ADDR, 8'h10);
      settle();
      check(rateWire, 1'b0);
      wr(PIN_FUNCTION_CONFIG_ADDR, 8'h00);
   endtask
   task automatic t_loss();
      wr(LOSS_THRESHOLD_ADDR, 8'h80);
      for (int p = 0; p < 2; p++)
      begin
         wr(OUTPUT_CONFIG_ADDR, 8'(p << 3));
         level <= 8'h40;
         settle();
         check(lossWire, !p[0]);
         rdr(STATUS_ADDR);
         check(rd[0], 1'b1);
         level <= 8'h90;
         settle();
         check(lossWire, p[0]);
         level <= 8'h80;
         settle();
         check(lossWire, p[0]);
         extPull <= 1'b1;
         settle();
         rdr(STATUS_ADDR);
         check(rd[0], p[0]);
         extPull <= 1'b0;
         level <= 8'h90;
      end
   endtask
   task automatic t_tx();
      wr(OUTPUT_CONFIG_ADDR, 8'h04);
      for (int i = 0; i < 4; i++)
      begin
         wr(RATE_CONTROL_ADDR, {6'h0, i[1], 1'b0});
         txIn <= i[0];
         settle();
         check(lossWire, i[0] | i[1]);
         check(lossPinOut, 1'b0);
      end
      wr(OUTPUT_CONFIG_ADDR, 8'h00);
   endtask
   task automatic t_uv();
      check(shutdownReq, 1'b0);
      uv <= 1'b1;
      settle();
      check({shutdownReq, convEnable}, 2'b10);
      rdr(STATUS_ADDR);
      check(rd[3:2], 2'b10);
   endtask
   always @(posedge clk)
   begin
      cycles++;
      if (cycles == 5000)
      begin
         errors++;
         conclude();
      end
   end
   initial
   begin
      repeat (4) @(posedge clk);
      arst_n <= 1'b1;
      t_reset();
      t_rx();
      t_gpo();
      t_loss();
      t_tx();
      t_uv();
      conclude();
   end
endmodule
